// *** design/dts_ctrl.sv ***
// dual channel temperature sensor control: sequencing, limits, alert, apb registers
// How it works
// R01 - the serial interface is reset once the bus clock has stayed low for the bus timeout.
// R02 - the two address select pins are caught once after reset and form the slave address.
// R03 - a low standby pin stops conversions and a high one resumes normal operation.
// R04 - results and alarm limits are left untouched while in standby.
// R05 - every run converts the local channel and then the remote channel.
// R06 - each finished run loads both results and compares them with the four limits.
// R07 - in legacy resolution each channel integrates for 60 ms.
// R08 - extended resolution doubles the length of a run.
// R09 - results carry 11 bits, with the low three cleared in legacy resolution.
// R10 - the alert pin is open drain and only ever pulls low.
// R11 - runs repeat while the halt bit is clear, or one run follows a one-shot command.
// R12 - busy is shown during a run while the previous results stay readable.
// R13 - a legacy run lasts 125 ms from its start, inside 95 to 156 ms.
// R14 - alert is raised when a result lies above its high or below its low limit.
`timescale 1ns/1ps
`default_nettype none
module dts_ctrl
	import dts_pkg::*;
#(
	parameter int MS_CYCLES = DTS_MS_CYC,
	parameter int RES_W = 11
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic serial_clock_pin,
	input wire logic addr_select_lo,
	input wire logic addr_select_hi,
	input wire logic standby_pin_n,
	output logic alert_n_o,
	output logic alert_n_oe,
	// converter front end
	input wire logic [RES_W-1:0] local_adc_data,
	input wire logic [RES_W-1:0] remote_adc_data,
	output logic adc_sel_remote,
	// system
	output logic serial_if_reset,
	output logic slave_addr_valid,
	output logic [6:0] slave_addr,
	output logic irq
);
	logic ms_tick;
	logic scl_s, standby_pin_n_n_s, addr_lo_s, addr_hi_s;
	dts_state_t st_r, st_nxt;
	logic [7:0] ms_cnt_r, phase_len;
	logic halt_r, ext_r, oneshot_r;
	logic [RES_W-1:0] loc_res_r, rem_res_r, loc_hold_r;
	logic [RES_W-1:0] loc_hi_r, loc_lo_r, rem_hi_r, rem_lo_r;
	logic [DTS_INT_W-1:0] int_stat_r, int_mask_r, int_set, int_clr;
	logic [7:0] scl_low_ms_r;
	logic [1:0] addr_wait_r;
	logic tmo_done_r;

	dts_tick #(.DIV(MS_CYCLES)) u_tick (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.tick(ms_tick)
	);

	dts_sync #(.W(4)) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.async_in({serial_clock_pin, standby_pin_n, addr_select_lo, addr_select_hi}),
		.sync_out({scl_s, standby_pin_n_n_s, addr_lo_s, addr_hi_s})
	);

	// apb decode: one wait state so read data comes from a flop
	wire acc_first = psel && penable && !pready;
	wire acc_done = psel && penable && pready;
	wire wr_go = acc_done && pwrite;
	wire sel_ctrl = (paddr == DTS_OFF_CTRL);
	wire sel_stat = (paddr == DTS_OFF_STAT);
	wire sel_lres = (paddr == DTS_OFF_LOC_RES);
	wire sel_rres = (paddr == DTS_OFF_REM_RES);
	wire sel_lhi = (paddr == DTS_OFF_LOC_HI);
	wire sel_llo = (paddr == DTS_OFF_LOC_LO);
	wire sel_rhi = (paddr == DTS_OFF_REM_HI);
	wire sel_rlo = (paddr == DTS_OFF_REM_LO);
	wire sel_ist = (paddr == DTS_OFF_INT_STAT);
	wire sel_imk = (paddr == DTS_OFF_INT_MASK);
	wire sel_adr = (paddr == DTS_OFF_ADDR);
	wire mapped = sel_ctrl | sel_stat | sel_lres | sel_rres | sel_lhi | sel_llo |
		sel_rhi | sel_rlo | sel_ist | sel_imk | sel_adr;
	wire standby = !standby_pin_n_n_s;
	wire busy = (st_r != DTS_IDLE);
	wire [31:0] rd_mux =
		sel_ctrl ? {29'h0, oneshot_r, ext_r, halt_r} :
		sel_stat ? {29'h0, slave_addr_valid, standby, busy} :
		sel_lres ? {21'h0, loc_res_r} :
		sel_rres ? {21'h0, rem_res_r} :
		sel_lhi ? {21'h0, loc_hi_r} :
		sel_llo ? {21'h0, loc_lo_r} :
		sel_rhi ? {21'h0, rem_hi_r} :
		sel_rlo ? {21'h0, rem_lo_r} :
		sel_ist ? {28'h0, int_stat_r} :
		sel_imk ? {28'h0, int_mask_r} :
		sel_adr ? {24'h0, 1'b0, slave_addr} : 32'h0000_0000;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= acc_first;
			pslverr <= acc_first && !mapped;
			prdata <= (acc_first && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// control, limits and mask; limits have no standby gating so they persist [R04]
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			{ext_r, halt_r} <= DTS_CTRL_RST[1:0];
			loc_hi_r <= DTS_HI_RST;
			rem_hi_r <= DTS_HI_RST;
			loc_lo_r <= DTS_LO_RST;
			rem_lo_r <= DTS_LO_RST;
			int_mask_r <= DTS_MASK_RST;
		end else if (wr_go) begin
			if (sel_ctrl) halt_r <= pwdata[DTS_CTRL_HALT];
			if (sel_ctrl) ext_r <= pwdata[DTS_CTRL_EXT];
			if (sel_lhi) loc_hi_r <= pwdata[RES_W-1:0];
			if (sel_llo) loc_lo_r <= pwdata[RES_W-1:0];
			if (sel_rhi) rem_hi_r <= pwdata[RES_W-1:0];
			if (sel_rlo) rem_lo_r <= pwdata[RES_W-1:0];
			if (sel_imk) int_mask_r <= pwdata[DTS_INT_W-1:0];
		end
	end

	// one-shot request waits until the sequencer is idle and awake [R11]
	wire start = (st_r == DTS_IDLE) && !standby && (!halt_r || oneshot_r);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			oneshot_r <= 1'b0;
		end else if (wr_go && sel_ctrl && pwdata[DTS_CTRL_ONESHOT]) begin
			oneshot_r <= 1'b1;
		end else if (start) begin
			oneshot_r <= 1'b0;
		end
	end

	// run = settle 5 ms + local + remote: 125 ms legacy, doubled when extended [R07] [R08] [R13]
	assign phase_len = (st_r == DTS_SETTLE) ? (ext_r ? DTS_SETTLE_MS << 1 : DTS_SETTLE_MS) :
		(ext_r ? DTS_INTEG_MS << 1 : DTS_INTEG_MS);
	// compare with >= so a resolution change in mid phase cannot push the count past its end
	wire phase_end = ms_tick && (ms_cnt_r >= phase_len - 8'h01);
	wire run_end = phase_end && (st_r == DTS_REMOTE);

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			DTS_IDLE: if (start) st_nxt = DTS_SETTLE; // [R11]
			DTS_SETTLE: if (phase_end) st_nxt = DTS_LOCAL;
			DTS_LOCAL: if (phase_end) st_nxt = DTS_REMOTE; // [R05]
			DTS_REMOTE: if (phase_end) st_nxt = DTS_IDLE;
			default: st_nxt = DTS_IDLE;
		endcase
		// standby abandons the run without touching results [R03]
		if (standby) st_nxt = DTS_IDLE;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st_r <= DTS_IDLE;
			ms_cnt_r <= 8'h00;
		end else begin
			st_r <= st_nxt;
			if (st_nxt != st_r || st_r == DTS_IDLE) ms_cnt_r <= 8'h00;
			else if (ms_tick) ms_cnt_r <= ms_cnt_r + 8'h01;
		end
	end

	// local sample is held privately so the old pair stays readable during the run [R12]
	wire [RES_W-1:0] res_mask = ext_r ? {RES_W{1'b1}} : DTS_LEGACY_MASK[RES_W-1:0];
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			loc_hold_r <= '0;
			loc_res_r <= '0;
			rem_res_r <= '0;
		end else if (phase_end && st_r == DTS_LOCAL) begin
			loc_hold_r <= local_adc_data & res_mask; // [R09]
		end else if (run_end && !standby) begin
			loc_res_r <= loc_hold_r; // [R06]
			rem_res_r <= remote_adc_data & res_mask; // [R09]
		end
	end

	// two's complement compare of the fresh results against all four limits [R06] [R14]
	wire [RES_W-1:0] rem_new = remote_adc_data & res_mask;
	wire loc_out = ($signed(loc_hold_r) > $signed(loc_hi_r)) ||
		($signed(loc_hold_r) < $signed(loc_lo_r));
	wire rem_out = ($signed(rem_new) > $signed(rem_hi_r)) ||
		($signed(rem_new) < $signed(rem_lo_r));
	wire run_fin = run_end && !standby;

	// bus clock low watchdog; one pulse per low stretch [R01]
	wire tmo_hit = ms_tick && !scl_s && (scl_low_ms_r == DTS_TMO_MS - 8'h01) && !tmo_done_r;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			scl_low_ms_r <= 8'h00;
			tmo_done_r <= 1'b0;
			serial_if_reset <= 1'b0;
		end else begin
			serial_if_reset <= tmo_hit; // [R01]
			if (scl_s) begin
				scl_low_ms_r <= 8'h00;
				tmo_done_r <= 1'b0;
			end else if (tmo_hit) begin
				tmo_done_r <= 1'b1;
			end else if (ms_tick && !tmo_done_r) begin
				scl_low_ms_r <= scl_low_ms_r + 8'h01;
			end
		end
	end

	// interrupt status: write one to clear, a same-cycle event wins
	assign int_set = {tmo_hit, run_fin && rem_out, run_fin && loc_out, run_fin};
	assign int_clr = (wr_go && sel_ist) ? pwdata[DTS_INT_W-1:0] : '0;
	wire int_any = |(((int_stat_r & ~int_clr) | int_set) & int_mask_r);
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			int_stat_r <= '0;
			irq <= 1'b0;
			alert_n_oe <= 1'b0;
			alert_n_o <= 1'b0;
			adc_sel_remote <= 1'b0;
		end else begin
			int_stat_r <= (int_stat_r & ~int_clr) | int_set;
			irq <= int_any;
			alert_n_oe <= int_any; // open drain: only pulls low [R10] [R14]
			alert_n_o <= 1'b0; // [R10]
			adc_sel_remote <= (st_nxt == DTS_REMOTE);
		end
	end

	// address pins caught once the synchroniser has filled after reset [R02]
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			addr_wait_r <= 2'h0;
			slave_addr_valid <= 1'b0;
			slave_addr <= 7'h00;
		end else if (!slave_addr_valid) begin
			addr_wait_r <= addr_wait_r + 2'h1;
			if (addr_wait_r == 2'(DTS_SYNC_WAIT)) begin
				slave_addr_valid <= 1'b1;
				slave_addr <= {DTS_SLV_BASE[6:2], addr_hi_s, addr_lo_s}; // [R02]
			end
		end
	end

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_local_done;
		st_r == DTS_LOCAL && phase_end && !standby;
	endsequence
	sequence s_remote_phase;
		st_r == DTS_REMOTE;
	endsequence
	sequence s_loc_flag;
		run_fin && loc_out && int_mask_r[DTS_INT_LOC_LIM];
	endsequence

	tmo_pulse_a: assert property (tmo_hit |=> serial_if_reset ##1 !serial_if_reset) // [R01]
		else $error("bus timeout did not give one reset pulse");
	tmo_low_a: assert property ($rose(serial_if_reset) |-> !$past(scl_s)) // [R01]
		else $error("serial reset with bus clock high");
	addr_fixed_a: assert property (slave_addr_valid |=> $stable(slave_addr)) // [R02]
		else $error("slave address changed after capture");
	standby_stop_a: assert property (standby |=> st_r == DTS_IDLE) // [R03]
		else $error("sequencer ran in standby");
	standby_keep_a: assert property (standby && !wr_go |=> $stable(loc_res_r) && $stable(loc_hi_r)) // [R04]
		else $error("data changed in standby");
	both_chan_a: assert property (s_local_done |=> s_remote_phase) // [R05]
		else $error("remote channel skipped");
	load_res_a: assert property (run_fin |=> rem_res_r == $past(rem_new)) // [R06]
		else $error("remote result not loaded");
	integ_len_a: assert property (st_r == DTS_LOCAL && !ext_r |-> ms_cnt_r < DTS_INTEG_MS) // [R07]
		else $error("legacy integration overran");
	ext_double_a: assert property (st_r == DTS_LOCAL && ext_r |-> phase_len == 8'h78) // [R08]
		else $error("extended phase not doubled");
	legacy_bits_a: assert property (!ext_r && run_fin |=> rem_res_r[2:0] == 3'h0) // [R09]
		else $error("legacy result has fraction bits");
	alert_drive_a: assert property (alert_n_oe |-> !alert_n_o) // [R10]
		else $error("alert driven high");
	auto_run_a: assert property (st_r == DTS_IDLE && !halt_r && !standby |=> busy) // [R11]
		else $error("autoconvert did not start");
	busy_keep_a: assert property (busy && !run_end |=> $stable(loc_res_r)) // [R12]
		else $error("result changed mid run");
	limit_alert_a: assert property (s_loc_flag |=> alert_n_oe) // [R14]
		else $error("out of limit did not pull alert");
endmodule
`default_nettype wire

// *** design/dts_pkg.sv ***
// constants shared by the dual channel temperature sensor control block
package dts_pkg;
	// register byte offsets
	localparam logic [7:0] DTS_OFF_CTRL = 8'h00;
	localparam logic [7:0] DTS_OFF_STAT = 8'h04;
	localparam logic [7:0] DTS_OFF_LOC_RES = 8'h08;
	localparam logic [7:0] DTS_OFF_REM_RES = 8'h0C;
	localparam logic [7:0] DTS_OFF_LOC_HI = 8'h10;
	localparam logic [7:0] DTS_OFF_LOC_LO = 8'h14;
	localparam logic [7:0] DTS_OFF_REM_HI = 8'h18;
	localparam logic [7:0] DTS_OFF_REM_LO = 8'h1C;
	localparam logic [7:0] DTS_OFF_INT_STAT = 8'h20;
	localparam logic [7:0] DTS_OFF_INT_MASK = 8'h24;
	localparam logic [7:0] DTS_OFF_ADDR = 8'h28;
	// control fields
	localparam int DTS_CTRL_HALT = 0;
	localparam int DTS_CTRL_EXT = 1;
	localparam int DTS_CTRL_ONESHOT = 2;
	// status fields
	localparam int DTS_STAT_BUSY = 0;
	localparam int DTS_STAT_STANDBY_PIN_N = 1;
	localparam int DTS_STAT_ADDR_OK = 2;
	// interrupt fields
	localparam int DTS_INT_W = 4;
	localparam int DTS_INT_DONE = 0;
	localparam int DTS_INT_LOC_LIM = 1;
	localparam int DTS_INT_REM_LIM = 2;
	localparam int DTS_INT_TMO = 3;
	// reset values
	localparam logic [2:0] DTS_CTRL_RST = 3'h0;
	localparam logic [10:0] DTS_HI_RST = 11'h3F8;
	localparam logic [10:0] DTS_LO_RST = 11'h400;
	localparam logic [3:0] DTS_MASK_RST = 4'h0;
	localparam logic [7:0] DTS_SLV_BASE = 8'h18;
	// timing, in the printed units
	localparam int DTS_CLK_NS = 40;
	localparam int DTS_MS_NS = 1_000_000;
	localparam int DTS_MS_CYC = DTS_MS_NS / DTS_CLK_NS;
	localparam logic [7:0] DTS_INTEG_MS = 8'h3C;
	localparam logic [7:0] DTS_SETTLE_MS = 8'h05;
	localparam logic [7:0] DTS_TMO_MS = 8'h1E;
	localparam int DTS_SYNC_WAIT = 2;
	// legacy mode drops the three fraction bits
	localparam logic [10:0] DTS_LEGACY_MASK = 11'h7F8;
	typedef enum logic [1:0] {DTS_IDLE, DTS_SETTLE, DTS_LOCAL, DTS_REMOTE} dts_state_t;
endpackage

// *** design/dts_sync.sv ***
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module dts_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// data
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule
`default_nettype wire

// *** design/dts_tick.sv ***
// divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ps
`default_nettype none
module dts_tick #(
	parameter int DIV = 25000
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// pulse
	output logic tick
);
	localparam int CW = $clog2(DIV + 1);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);
	logic [CW-1:0] cnt_r;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
			tick <= (cnt_r == LAST);
		end
	end
endmodule
`default_nettype wire

// *** testbench/dts_host_model.sv ***
// host side model driving the bus clock pin
`timescale 1ns/1ps
`default_nettype none
module dts_host_model (
	// bus clock pin, idle high through the pull-up
	output var logic serial_clock_pin
);
	initial serial_clock_pin = 1'b1;
	// clock runs only inside frames, 320 ns period, edges 7 ns after a sys_clk rising edge
	task automatic frame(input int bits);
		#7;
		repeat (bits) begin
			serial_clock_pin = 1'b0;
			#160;
			serial_clock_pin = 1'b1;
			#160;
		end
	endtask
	// stuck-low fault, the only way to provoke the bus timeout
	task automatic hold_low(input int ns);
		#7;
		serial_clock_pin = 1'b0;
		#(ns);
		serial_clock_pin = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** testbench/dual_channel_temp_sensor_control_bench.sv ***
// self-checking bench for the temperature sensor control block
`timescale 1ns/1ps
`default_nettype none
module dual_channel_temp_sensor_control_bench
	import dts_pkg::*;
;
	// a short millisecond keeps a full run near 1250 cycles
	localparam int MS = 10;
	logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic addr_select_lo, addr_select_hi, standby_pin_n, alert_n_o, alert_n_oe;
	logic [10:0] local_adc_data, remote_adc_data;
	logic adc_sel_remote, serial_if_reset, slave_addr_valid, irq, sel_q;
	logic [6:0] slave_addr;
	wire serial_clock_pin;
	int bad_count, comparisons, cyc, tmo_pulses, sel_rises, t, d;

	dts_host_model host (.serial_clock_pin(serial_clock_pin));
	dts_ctrl #(.MS_CYCLES(MS)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .serial_clock_pin(serial_clock_pin),
		.addr_select_lo(addr_select_lo), .addr_select_hi(addr_select_hi),
		.standby_pin_n(standby_pin_n), .alert_n_o(alert_n_o), .alert_n_oe(alert_n_oe),
		.local_adc_data(local_adc_data), .remote_adc_data(remote_adc_data),
		.adc_sel_remote(adc_sel_remote), .serial_if_reset(serial_if_reset),
		.slave_addr_valid(slave_addr_valid), .slave_addr(slave_addr), .irq(irq));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic end_of_test();
		if (bad_count == 0 && comparisons > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// watchdog plus counters of remote phases and timeout pulses
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		sel_q <= adc_sel_remote;
		if (adc_sel_remote === 1'b1 && sel_q !== 1'b1) sel_rises <= sel_rises + 1;
		if (serial_if_reset === 1'b1) tmo_pulses <= tmo_pulses + 1;
		if (cyc > 40000) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_win(input int got, input int lo, input int hi);
		comparisons++;
		if (got < lo || got > hi) begin
			bad_count++;
			$display("ERROR %0t count %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	// request held until pready is sampled high, then released
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		penable <= 1'b0;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		v = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic err = 1'b0);
		xfer(1'b1, a, wd);
		chk({31'h0, e}, {31'h0, err});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err = 1'b0);
		xfer(1'b0, a, 32'h0000_0000);
		chk(v, exp);
		chk({31'h0, e}, {31'h0, err});
	endtask

	// polls the run-done flag; t holds the cycle it was seen
	task automatic wait_done();
		t = 0;
		for (int i = 0; i < 3000; i++) begin
			xfer(1'b0, DTS_OFF_INT_STAT, 32'h0000_0000);
			if (v[DTS_INT_DONE] === 1'b1) begin
				t = cyc;
				break;
			end
		end
		if (t == 0) begin
			bad_count++;
			$display("ERROR %0t run never finished", $time);
		end
	endtask

	// length of one whole run between two done events
	task automatic measure();
		int t0, s;
		wr(DTS_OFF_INT_STAT, 32'h0000_0001);
		wait_done();
		t0 = t;
		s = sel_rises;
		wr(DTS_OFF_INT_STAT, 32'h0000_0001);
		wait_done();
		d = t - t0;
		chk_win(sel_rises - s, 1, 1);
	endtask

	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		addr_select_lo = 1'b0;
		addr_select_hi = 1'b1;
		standby_pin_n = 1'b1;
		local_adc_data = 11'h0C9;
		remote_adc_data = 11'h105;
		repeat (4) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(DTS_OFF_CTRL, 32'h0000_0000);
		rd(DTS_OFF_LOC_HI, 32'h0000_03F8);
		rd(DTS_OFF_REM_LO, 32'h0000_0400);
		rd(DTS_OFF_INT_MASK, 32'h0000_0000);
		rd(8'h30, 32'h0000_0000, 1'b1);
		wr(8'h30, 32'h0000_FFFF, 1'b1);
		// straps move after capture and must be ignored
		addr_select_hi <= 1'b0;
		addr_select_lo <= 1'b1;
		rd(DTS_OFF_ADDR, 32'h0000_001A);
		chk({24'h0, slave_addr_valid, slave_addr}, 32'h0000_009A);
		wait_done();
		rd(DTS_OFF_LOC_RES, 32'h0000_00C8);
		rd(DTS_OFF_REM_RES, 32'h0000_0100);
		measure();
		chk_win(d, 125 * MS - 40, 125 * MS + 20);
		wr(DTS_OFF_CTRL, 32'h0000_0002);
		rd(DTS_OFF_STAT, 32'h0000_0005);
		rd(DTS_OFF_LOC_RES, 32'h0000_00C8);
		measure();
		chk_win(d, 250 * MS - 60, 250 * MS + 20);
		rd(DTS_OFF_LOC_RES, 32'h0000_00C9);
		// limits below and above the results raise both channel flags
		wr(DTS_OFF_CTRL, 32'h0000_0000);
		wr(DTS_OFF_LOC_HI, 32'h0000_0010);
		wr(DTS_OFF_REM_LO, 32'h0000_0200);
		wr(DTS_OFF_INT_MASK, 32'h0000_0002);
		measure();
		rd(DTS_OFF_INT_STAT, 32'h0000_0007);
		chk({29'h0, irq, alert_n_oe, alert_n_o}, 32'h0000_0006);
		wr(DTS_OFF_INT_MASK, 32'h0000_0000);
		repeat (2) @(posedge sys_clk);
		chk({29'h0, irq, alert_n_oe, alert_n_o}, 32'h0000_0000);
		wr(DTS_OFF_LOC_HI, 32'h0000_03F8);
		wr(DTS_OFF_REM_LO, 32'h0000_0400);
		wr(DTS_OFF_INT_MASK, 32'h0000_0002);
		measure();
		wr(DTS_OFF_INT_STAT, 32'h0000_0006);
		repeat (2) @(posedge sys_clk);
		chk({31'h0, irq}, 32'h0000_0000);
		rd(DTS_OFF_INT_STAT, 32'h0000_0001);
		// halted: no run without a one-shot, then exactly one
		wr(DTS_OFF_CTRL, 32'h0000_0001);
		repeat (260 * MS) @(posedge sys_clk);
		wr(DTS_OFF_INT_STAT, 32'h0000_000F);
		repeat (140 * MS) @(posedge sys_clk);
		rd(DTS_OFF_INT_STAT, 32'h0000_0000);
		wr(DTS_OFF_CTRL, 32'h0000_0005);
		wait_done();
		wr(DTS_OFF_INT_STAT, 32'h0000_0001);
		repeat (140 * MS) @(posedge sys_clk);
		rd(DTS_OFF_INT_STAT, 32'h0000_0000);
		// standby holds off conversions and keeps stored data
		local_adc_data <= 11'h0A1;
		standby_pin_n <= 1'b0;
		repeat (5) @(posedge sys_clk);
		rd(DTS_OFF_STAT, 32'h0000_0006);
		wr(DTS_OFF_CTRL, 32'h0000_0000);
		repeat (140 * MS) @(posedge sys_clk);
		rd(DTS_OFF_INT_STAT, 32'h0000_0000);
		rd(DTS_OFF_LOC_RES, 32'h0000_00C8);
		rd(DTS_OFF_LOC_HI, 32'h0000_03F8);
		standby_pin_n <= 1'b1;
		wait_done();
		rd(DTS_OFF_LOC_RES, 32'h0000_00A0);
		// normal frames and a short low never reset the interface
		host.frame(18);
		chk(tmo_pulses, 0);
		host.hold_low(20 * MS * 40);
		repeat (4) @(posedge sys_clk);
		chk(tmo_pulses, 0);
		host.hold_low(35 * MS * 40);
		repeat (4) @(posedge sys_clk);
		chk(tmo_pulses, 1);
		xfer(1'b0, DTS_OFF_INT_STAT, 32'h0000_0000);
		chk({31'h0, v[DTS_INT_TMO]}, 32'h0000_0001);
		end_of_test();
	end
endmodule
`default_nettype wire
